// ==== rtl/bsm_pkg.sv ====
package bsm_pkg;
  // Timing base of all wait settings: one step is 10 ms
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned WAIT_STEP_NS = 10_000_000;
  localparam int unsigned WAIT_STEP_CYC = WAIT_STEP_NS / CLK_PERIOD_NS;
  localparam logic [8:0] WAIT_MAX = 9'h1f4;

  // Settling count for the variant strap after reset release
  localparam logic [2:0] STRAP_SETTLE = 3'h5;

  // Configuration port addresses
  localparam logic [4:0] AD_EN = 5'h00;
  localparam logic [4:0] AD_REL_WAIT = 5'h01;
  localparam logic [4:0] AD_ACC_WAIT = 5'h02;
  localparam logic [4:0] AD_STP_WAIT = 5'h03;
  localparam logic [4:0] AD_CNF_WAIT = 5'h04;
  localparam logic [4:0] AD_REL_FREQ = 5'h05;
  localparam logic [4:0] AD_CUR_MIN = 5'h06;
  localparam logic [4:0] AD_FN0 = 5'h08;
  localparam logic [4:0] AD_POL0 = 5'h10;
  localparam logic [4:0] AD_FWD_POL = 5'h18;

  localparam int unsigned NTERM = 8;
  localparam int unsigned FN_W = 6;
  localparam int unsigned NFUNC = 64;

  // Option codes
  localparam logic [1:0] EN_ON = 2'h0;
  localparam logic [5:0] FN_REV = 6'h01;
  localparam logic [5:0] FN_CLR = 6'h12;
  localparam logic [5:0] FN_US6 = 6'h0d;

  // Reset values
  localparam logic [1:0] EN_DEF = 2'h0;
  localparam logic [8:0] WAIT_DEF = 9'h000;
  localparam logic [15:0] REL_FREQ_DEF = 16'h0000;
  localparam logic [7:0] CUR_MIN_DEF = 8'h64;
  localparam logic [NTERM-1:0][FN_W-1:0] FN_DEF =
    {6'h01, 6'h02, 6'h03, 6'h09, 6'h0b, 6'h06, 6'h10, 6'h12};
  localparam logic [NTERM-1:0] POL_DEF = 8'h00;
  localparam int unsigned US_TERM = 5;

  typedef struct packed {
    logic [1:0] en_sel;
    logic [8:0] rel_wait;
    logic [8:0] acc_wait;
    logic [8:0] stp_wait;
    logic [8:0] cnf_wait;
    logic [15:0] rel_freq;
    logic [7:0] cur_min;
  } bsm_brake_cfg_t;

  typedef struct packed {
    logic [NTERM-1:0][FN_W-1:0] fn;
    logic [NTERM-1:0] pol;
    logic fwd_pol;
  } bsm_term_cfg_t;

  typedef enum logic [3:0] {
    S_IDLE, S_REL_WAIT, S_CNF_ON, S_ACC_WAIT, S_RUN,
    S_CNF_OFF, S_STP_WAIT, S_DECEL, S_TRIP
  } bsm_state_t;
endpackage

// ==== rtl/bsm_sync.sv ====
`timescale 1ns/1ns
// Three-stage pin synchroniser; a bit changes only when stages two and three agree
module bsm_sync #(
  parameter int unsigned W = 1
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;
  logic [W-1:0] next_q;

  always_comb
  begin
    next_q = (~(ff2 ^ ff3) & ff3) | ((ff2 ^ ff3) & q_o);
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ff1 <= '0;
      ff2 <= '0;
      ff3 <= '0;
      q_o <= '0;
    end
    else
    begin
      ff1 <= pin_i;
      ff2 <= ff1;
      ff3 <= ff2;
      q_o <= next_q;
    end
  end
endmodule

// ==== rtl/bsm_brake_sequencer_input_mapper.sv ====
// Contract
// - Release output waits the release wait time after frequency reaches release frequency.
// - After confirmation, hold frequency for the acceleration wait time, then accelerate.
// - On stop, after confirmation drops, wait stop time before decelerating to 0 Hz.
// - Missing confirmation within the confirm wait time trips with a brake error.
// - Release frequency setting starts the release wait; default zero.
// - Release only while output current exceeds the minimum; default rated current.
// - Eight input terminals, each with a selector choosing one of 64 functions.
// - Each input is one bit: OFF is 0, ON is 1.
// - A selector holds a discrete option code; code 01 means reverse run.
// - One function on several terminals is the OR of those terminals.
// - Default selector codes 18,16,06,11,09,03,02,01; US variant terminal six 13.
// - Each terminal and forward terminal has polarity: 00 active high, 01 inverted.
// - Polarity resets to 00, except terminal six 01 in the US variant.
// - A terminal with code 18 ignores inverted polarity and stays active high.
// - Code 01 terminal ON runs reverse, OFF stops.
`timescale 1ns/1ns
module bsm_brake_sequencer_input_mapper
  import bsm_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = WAIT_STEP_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic us_variant_i,
  input wire logic cfg_wr_i,
  input wire logic [4:0] cfg_addr_i,
  input wire logic [15:0] cfg_data_i,
  input wire logic [NTERM-1:0] term_pin_i,
  input wire logic fwd_pin_i,
  input wire logic brake_confirm_pin_i,
  input wire logic run_cmd_i,
  input wire logic [15:0] out_freq_i,
  input wire logic [7:0] out_current_pct_i,
  output logic brake_release_o,
  output logic hold_freq_o,
  output logic accel_ok_o,
  output logic decel_ok_o,
  output logic brake_error_o,
  output logic [NFUNC-1:0] func_o,
  output logic forward_run_o,
  output logic reverse_run_o
);
  bsm_brake_cfg_t bcfg;
  bsm_brake_cfg_t next_bcfg;
  bsm_term_cfg_t tcfg;
  bsm_term_cfg_t next_tcfg;
  logic [2:0] settle;
  logic [2:0] next_settle;
  logic [NTERM+2:0] sync_q;
  logic [NTERM-1:0] term_in;
  logic fwd_in;
  logic confirm;
  logic us_strap;

  bsm_sync #(.W(NTERM + 3)) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .pin_i({us_variant_i, brake_confirm_pin_i, fwd_pin_i, term_pin_i}),
    .q_o(sync_q)
  );
  assign term_in = sync_q[NTERM-1:0];
  assign fwd_in = sync_q[NTERM];
  assign confirm = sync_q[NTERM+1];
  assign us_strap = sync_q[NTERM+2];

  // Configuration store; the strap is applied once, after it has settled
  always_comb
  begin
    next_bcfg = bcfg;
    next_tcfg = tcfg;
    next_settle = settle;
    if (settle != STRAP_SETTLE)
    begin
      next_settle = settle + 3'h1;
      if (next_settle == STRAP_SETTLE && us_strap)
      begin
        next_tcfg.fn[US_TERM] = FN_US6;
        next_tcfg.pol[US_TERM] = 1'b1;
      end
    end
    if (cfg_wr_i)
    begin
      case (cfg_addr_i)
        AD_EN: next_bcfg.en_sel = cfg_data_i[1:0];
        AD_REL_WAIT: next_bcfg.rel_wait = cfg_data_i[8:0];
        AD_ACC_WAIT: next_bcfg.acc_wait = cfg_data_i[8:0];
        AD_STP_WAIT: next_bcfg.stp_wait = cfg_data_i[8:0];
        AD_CNF_WAIT: next_bcfg.cnf_wait = cfg_data_i[8:0];
        AD_REL_FREQ: next_bcfg.rel_freq = cfg_data_i;
        AD_CUR_MIN: next_bcfg.cur_min = cfg_data_i[7:0];
        AD_FWD_POL: next_tcfg.fwd_pol = cfg_data_i[0];
        default:
        begin
          for (int i = 0; i < NTERM; i++)
          begin
            if (cfg_addr_i == AD_FN0 + 5'(i))
              next_tcfg.fn[i] = cfg_data_i[FN_W-1:0];
            if (cfg_addr_i == AD_POL0 + 5'(i))
              next_tcfg.pol[i] = cfg_data_i[0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      bcfg <= '{EN_DEF, WAIT_DEF, WAIT_DEF, WAIT_DEF, WAIT_DEF, REL_FREQ_DEF, CUR_MIN_DEF};
      tcfg <= '{FN_DEF, POL_DEF, 1'b0};
      settle <= 3'h0;
    end
    else
    begin
      bcfg <= next_bcfg;
      tcfg <= next_tcfg;
      settle <= next_settle;
    end
  end

  // Terminal to function mapping
  logic [NTERM-1:0] term_act;
  logic [NTERM-1:0][NFUNC-1:0] term_hot;
  logic [NFUNC-1:0] next_func;
  genvar g;
  generate
    for (g = 0; g < NTERM; g++)
    begin : g_term
      // A fault-clear terminal is never inverted
      assign term_act[g] = term_in[g] ^ (tcfg.pol[g] && tcfg.fn[g] != FN_CLR);
      assign term_hot[g] = term_act[g] ? (NFUNC'(1) << tcfg.fn[g]) : '0;
    end
  endgenerate

  always_comb
  begin
    next_func = '0;
    for (int i = 0; i < NTERM; i++)
      next_func = next_func | term_hot[i];
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      func_o <= '0;
      forward_run_o <= 1'b0;
      reverse_run_o <= 1'b0;
    end
    else
    begin
      func_o <= next_func;
      forward_run_o <= fwd_in ^ tcfg.fwd_pol;
      reverse_run_o <= next_func[FN_REV];
    end
  end

  // Brake sequencer
  bsm_state_t state;
  bsm_state_t next_state;
  logic [17:0] pre;
  logic [17:0] next_pre;
  logic [8:0] elapsed;
  logic [8:0] next_elapsed;
  logic next_error;
  logic en;
  logic cur_ok;
  logic freq_ok;

  assign en = bcfg.en_sel == EN_ON;
  assign cur_ok = out_current_pct_i > bcfg.cur_min;
  assign freq_ok = out_freq_i >= bcfg.rel_freq;

  always_comb
  begin
    next_state = state;
    next_error = brake_error_o;
    next_pre = pre + 18'h1;
    next_elapsed = elapsed;
    if (pre >= 18'(STEP_CYCLES - 1))
    begin
      next_pre = '0;
      if (elapsed != WAIT_MAX)
        next_elapsed = elapsed + 9'h1;
    end
    case (state)
      S_IDLE:
        if (run_cmd_i && freq_ok)
          next_state = S_REL_WAIT;
      S_REL_WAIT:
        if (!run_cmd_i)
          next_state = S_IDLE;
        else if (elapsed >= bcfg.rel_wait && cur_ok)
          next_state = S_CNF_ON;
      S_CNF_ON:
        if (confirm)
          next_state = S_ACC_WAIT;
        else if (elapsed >= bcfg.cnf_wait)
          next_state = S_TRIP;
      S_ACC_WAIT:
        if (elapsed >= bcfg.acc_wait)
          next_state = S_RUN;
      S_RUN:
        if (!run_cmd_i)
          next_state = S_CNF_OFF;
      S_CNF_OFF:
        if (!confirm)
          next_state = S_STP_WAIT;
        else if (elapsed >= bcfg.cnf_wait)
          next_state = S_TRIP;
      S_STP_WAIT:
        if (elapsed >= bcfg.stp_wait)
          next_state = S_DECEL;
      S_DECEL:
        if (out_freq_i == 16'h0000)
          next_state = S_IDLE;
      S_TRIP:
        if (next_func[FN_CLR])
          next_state = S_IDLE;
      default:
        next_state = S_IDLE;
    endcase
    if (!en)
      next_state = S_IDLE;
    if (next_state == S_TRIP)
      next_error = 1'b1;
    else if (next_func[FN_CLR] || !en)
      next_error = 1'b0;
    // Each phase times from its own start
    if (next_state != state)
    begin
      next_pre = '0;
      next_elapsed = '0;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      state <= S_IDLE;
      pre <= '0;
      elapsed <= '0;
      brake_error_o <= 1'b0;
      brake_release_o <= 1'b0;
      hold_freq_o <= 1'b0;
      accel_ok_o <= 1'b1;
      decel_ok_o <= 1'b1;
    end
    else
    begin
      state <= next_state;
      pre <= next_pre;
      elapsed <= next_elapsed;
      brake_error_o <= next_error;
      brake_release_o <= next_state inside {S_CNF_ON, S_ACC_WAIT, S_RUN};
      hold_freq_o <= next_state inside {S_REL_WAIT, S_CNF_ON, S_ACC_WAIT,
                                        S_CNF_OFF, S_STP_WAIT};
      accel_ok_o <= !en || next_state == S_RUN;
      decel_ok_o <= !en || next_state inside {S_RUN, S_DECEL, S_IDLE};
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  rel_after_wait_a: assert property ($rose(brake_release_o) |-> $past(state) == S_REL_WAIT
    && $past(elapsed) >= $past(bcfg.rel_wait)) else $error("release before wait");
  rel_current_a: assert property ($rose(brake_release_o) |->
    $past(out_current_pct_i) > $past(bcfg.cur_min)) else $error("release with low current");
  accel_hold_a: assert property ($rose(accel_ok_o) && en |-> $past(state) == S_ACC_WAIT
    && $past(elapsed) >= $past(bcfg.acc_wait)) else $error("accel too early");
  stop_wait_a: assert property (state == S_STP_WAIT && elapsed < bcfg.stp_wait && en
    ##1 en |-> !decel_ok_o) else $error("decel too early");
  confirm_trip_a: assert property (state == S_CNF_ON && !confirm && en
    && elapsed >= bcfg.cnf_wait |=> brake_error_o) else $error("missing brake trip");
  freq_start_a: assert property (state == S_IDLE && en && run_cmd_i && freq_ok
    |=> state == S_REL_WAIT) else $error("release wait not started");
  disabled_off_a: assert property (!en ##1 !en |->
    !brake_release_o && !brake_error_o) else $error("brake active while disabled");
  clr_no_invert_a: assert property (tcfg.fn[0] == FN_CLR && term_in[0] |=>
    func_o[FN_CLR]) else $error("clear terminal inverted");
  or_map_a: assert property (tcfg.fn[1] == tcfg.fn[2] && term_act[2] |=>
    func_o[$past(tcfg.fn[1])]) else $error("function OR lost");
  reverse_a: assert property (tcfg.fn[7] == FN_REV && term_act[7] |=> reverse_run_o)
    else $error("reverse run missing");
  defaults_a: assert property (@(posedge mclk_i) disable iff (1'b0) rst_i |=>
    tcfg.fn == FN_DEF && tcfg.pol == POL_DEF) else $error("bad terminal defaults");

  trip_c: cover property ($rose(brake_error_o));
  full_run_c: cover property ($rose(accel_ok_o) && brake_release_o);
  stop_c: cover property (state == S_STP_WAIT ##1 state == S_DECEL);
  us_c: cover property (tcfg.fn[US_TERM] == FN_US6 && tcfg.pol[US_TERM]);
endmodule

// ==== verification/bsm_brake_model.sv ====
`timescale 1ns/1ns
// Brake with its contact: the contact follows the release command after a travel time
module bsm_brake_model #(
  parameter int unsigned DELAY = 3
) (
  input wire logic mclk_i,
  input wire logic release_i,
  input wire logic stuck_i,
  output logic confirm_o
);
  logic [DELAY-1:0] travel = '0;
  always @(posedge mclk_i)
  begin
    travel <= {travel[DELAY-2:0], release_i};
  end
  // A seized brake never reports released, which is how the trip path is reached
  assign confirm_o = travel[DELAY-1] & ~stuck_i;
endmodule

// ==== verification/bsm_brake_sequencer_input_mapper_test.sv ====
`timescale 1ns/1ns
module bsm_brake_sequencer_input_mapper_test
  import bsm_pkg::*;
;
  localparam int STEP = 4;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic us_variant_i = 1'b0;
  logic cfg_wr_i = 1'b0;
  logic [4:0] cfg_addr_i = 5'h00;
  logic [15:0] cfg_data_i = 16'h0000;
  logic [NTERM-1:0] term_pin_i = '0;
  logic fwd_pin_i = 1'b0;
  logic brake_confirm_pin_i;
  logic run_cmd_i = 1'b0;
  logic [15:0] out_freq_i = 16'h0000;
  logic [7:0] out_current_pct_i = 8'h00;
  logic stuck = 1'b0;
  logic brake_release_o, hold_freq_o, accel_ok_o, decel_ok_o, brake_error_o;
  logic [NFUNC-1:0] func_o;
  logic forward_run_o, reverse_run_o;
  int n_errors = 0;
  int checks = 0;
  int n;
  logic [5:0] fn_exp [NTERM] = '{6'h12, 6'h10, 6'h06, 6'h0b, 6'h09, 6'h03, 6'h02, 6'h01};

  bsm_brake_sequencer_input_mapper #(.STEP_CYCLES(STEP)) i_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .us_variant_i(us_variant_i),
    .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i), .cfg_data_i(cfg_data_i),
    .term_pin_i(term_pin_i), .fwd_pin_i(fwd_pin_i),
    .brake_confirm_pin_i(brake_confirm_pin_i), .run_cmd_i(run_cmd_i),
    .out_freq_i(out_freq_i), .out_current_pct_i(out_current_pct_i),
    .brake_release_o(brake_release_o), .hold_freq_o(hold_freq_o),
    .accel_ok_o(accel_ok_o), .decel_ok_o(decel_ok_o), .brake_error_o(brake_error_o),
    .func_o(func_o), .forward_run_o(forward_run_o), .reverse_run_o(reverse_run_o)
  );

  bsm_brake_model #(.DELAY(3)) i_brake (
    .mclk_i(mclk_i), .release_i(brake_release_o), .stuck_i(stuck),
    .confirm_o(brake_confirm_pin_i)
  );

  initial
  begin
    forever #20 mclk_i = ~mclk_i;
  end

  task automatic cyc(input int k);
    repeat (k) @(negedge mclk_i);
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge mclk_i);
    cfg_wr_i = 1'b1;
    cfg_addr_i = a;
    cfg_data_i = d;
    @(negedge mclk_i);
    cfg_wr_i = 1'b0;
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: return brake_release_o;
      1: return accel_ok_o;
      2: return decel_ok_o;
      default: return brake_error_o;
    endcase
  endfunction

  // Bounded wait; a miss shows up as a count outside the expected window
  task automatic wait_lv(input int k, input logic v, output int cnt);
    cnt = 0;
    while (pick(k) !== v && cnt < 100)
    begin
      @(negedge mclk_i);
      cnt++;
    end
  endtask

  task automatic do_reset;
    rst_i = 1'b1;
    cyc(20);
    rst_i = 1'b0;
    // Long enough for the strap settle and the pin synchronisers
    cyc(10);
  endtask

  task automatic finish_test;
    $display("Checks %0d, errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial
  begin
    do_reset();
    chk("release", 1'b0, brake_release_o);
    chk("accel_ok", 1'b0, accel_ok_o);
    chk("decel_ok", 1'b1, decel_ok_o);
    chk("error", 1'b0, brake_error_o);
    chk("func", 64'h0, func_o);
    wr(AD_REL_WAIT, 16'h0002);
    wr(AD_ACC_WAIT, 16'h0003);
    wr(AD_STP_WAIT, 16'h0003);
    wr(AD_CNF_WAIT, 16'h0003);
    wr(AD_REL_FREQ, 16'h0064);
    wr(AD_CUR_MIN, 16'h0032);
    out_current_pct_i = 8'h3c;
    out_freq_i = 16'h0063;
    run_cmd_i = 1'b1;
    cyc(20);
    chk("release_low_freq", 1'b0, brake_release_o);
    out_freq_i = 16'h0064;
    wait_lv(0, 1'b1, n);
    chk("release_wait", 1'b1, n >= 2 * STEP && n <= 2 * STEP + 4);
    chk("hold", 1'b1, hold_freq_o);
    wait_lv(1, 1'b1, n);
    chk("accel_wait", 1'b1, n >= 3 * STEP + 6 && n <= 3 * STEP + 14);
    chk("hold_run", 1'b0, hold_freq_o);
    run_cmd_i = 1'b0;
    wait_lv(0, 1'b0, n);
    chk("release_off", 1'b1, n <= 3);
    wait_lv(2, 1'b1, n);
    chk("stop_wait", 1'b1, n >= 3 * STEP + 6 && n <= 3 * STEP + 14);
    chk("no_trip", 1'b0, brake_error_o);
    out_freq_i = 16'h0000;
    cyc(4);
    // Current exactly at the minimum must not release the brake
    stuck = 1'b1;
    out_current_pct_i = 8'h32;
    out_freq_i = 16'h0064;
    run_cmd_i = 1'b1;
    cyc(20);
    chk("release_low_cur", 1'b0, brake_release_o);
    out_current_pct_i = 8'h33;
    wait_lv(0, 1'b1, n);
    chk("release_cur", 1'b1, n <= 3);
    wait_lv(3, 1'b1, n);
    chk("confirm_wait", 1'b1, n >= 3 * STEP && n <= 3 * STEP + 3);
    run_cmd_i = 1'b0;
    out_freq_i = 16'h0000;
    term_pin_i = 8'h01;
    cyc(8);
    chk("trip_clear", 1'b0, brake_error_o);
    term_pin_i = 8'h00;
    wr(AD_EN, 16'h0001);
    out_freq_i = 16'h0064;
    run_cmd_i = 1'b1;
    cyc(40);
    chk("dis_release", 1'b0, brake_release_o);
    chk("dis_error", 1'b0, brake_error_o);
    chk("dis_accel", 1'b1, accel_ok_o);
    run_cmd_i = 1'b0;
    out_freq_i = 16'h0000;
    stuck = 1'b0;
    for (int t = 0; t < NTERM; t++)
    begin
      term_pin_i = 8'h01 << t;
      cyc(6);
      chk("func_default", 64'h1 << fn_exp[t], func_o);
      chk("reverse", t == 7, reverse_run_o);
    end
    term_pin_i = 8'h00;
    wr(AD_POL0 + 5'h01, 16'h0001);
    cyc(6);
    chk("func_inv", 64'h1 << 16, func_o);
    wr(AD_POL0, 16'h0001);
    cyc(6);
    chk("func_clr_noinv", 64'h1 << 16, func_o);
    term_pin_i = 8'h01;
    cyc(6);
    chk("func_clr_on", (64'h1 << 18) | (64'h1 << 16), func_o);
    term_pin_i = 8'h00;
    wr(AD_FWD_POL, 16'h0001);
    cyc(6);
    chk("fwd_inv", 1'b1, forward_run_o);
    fwd_pin_i = 1'b1;
    cyc(6);
    chk("fwd_inv_on", 1'b0, forward_run_o);
    wr(AD_POL0 + 5'h01, 16'h0000);
    wr(AD_FN0 + 5'h02, 16'h0010);
    term_pin_i = 8'h04;
    cyc(6);
    chk("func_or_one", 64'h1 << 16, func_o);
    term_pin_i = 8'h06;
    cyc(6);
    chk("func_or_both", 64'h1 << 16, func_o);
    term_pin_i = 8'h00;
    wr(AD_FN0, 16'h0001);
    wr(5'h1f, 16'h0001);
    cyc(6);
    chk("func_rev_inv", 64'h2, func_o);
    chk("reverse_inv", 1'b1, reverse_run_o);
    us_variant_i = 1'b1;
    do_reset();
    chk("func_us", 64'h1 << 13, func_o);
    chk("fwd_reset_pol", 1'b1, forward_run_o);
    finish_test();
  end

  // The whole sequence needs well under a thousand cycles
  initial
  begin
    cyc(5000);
    n_errors++;
    finish_test();
  end
endmodule
